// ### core/mgmt_attr_pkg.sv
// constants for the management register bank attribute logic
// assumes a 16-bit register word and a 5-bit direct register index
`default_nettype none
package mgmt_attr_pkg;
	localparam int DATA_W = 16;
	localparam int INDEX_W = 5;
	localparam int ATTR_W = 4;
	// register indices, hex
	localparam logic [4:0] IDX_MMD_CTRL = 5'h0d;
	localparam logic [4:0] IDX_MMD_DATA = 5'h0e;
	// software reset lives in the basic control register
	localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
	localparam int SOFT_RST_BIT = 15;
	// access-control register fields
	localparam int MMD_FUNC_MSB = 15;
	localparam int MMD_FUNC_LSB = 14;
	localparam int MMD_DEV_MSB = 4;
	localparam int MMD_DEV_LSB = 0;
	localparam logic [1:0] MMD_FUNC_ADDR = 2'h0;
	// bit attribute encodings
	typedef enum logic [3:0] {
		ATTR_RSVD,
		ATTR_RW,
		ATTR_RO,
		ATTR_WO,
		ATTR_WC,
		ATTR_WAC,
		ATTR_RC,
		ATTR_LL,
		ATTR_LH,
		ATTR_SC,
		ATTR_SS,
		ATTR_RW_WAC
	} attr_t;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] MMD_CTRL_RESET = 16'h0000;
	localparam logic [15:0] MMD_DATA_RESET = 16'h0000;
endpackage
`default_nettype wire

// ### core/mgmt_attr_bit.sv
// one register bit with a selectable access attribute
// assumes one-cycle read and write strobes from the decoder
`timescale 1ns/10ps
`default_nettype none
module mgmt_attr_bit #(
	parameter logic [3:0] ATTR = 4'h1,
	parameter logic RESET_VAL = 1'b0,
	parameter logic IMMUNE = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_soft_rst,
	input wire logic i_wr,
	input wire logic i_wdata,
	input wire logic i_rd,
	input wire logic i_cond,
	output logic o_val
);
	logic bit_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			bit_q <= RESET_VAL;
		else if (i_soft_rst && !IMMUNE)
			bit_q <= RESET_VAL;
		else
		begin
			unique case (mgmt_attr_pkg::attr_t'(ATTR))
				mgmt_attr_pkg::ATTR_RW, mgmt_attr_pkg::ATTR_WO:
					if (i_wr)
						bit_q <= i_wdata;
				mgmt_attr_pkg::ATTR_RO, mgmt_attr_pkg::ATTR_RSVD:
					bit_q <= i_cond;
				mgmt_attr_pkg::ATTR_WC:
					if (i_cond)
						bit_q <= 1'b1;
					else if (i_wr && i_wdata)
						bit_q <= 1'b0;
				// readable clear-on-write bits still need a set source
				mgmt_attr_pkg::ATTR_WAC, mgmt_attr_pkg::ATTR_RW_WAC:
					if (i_cond)
						bit_q <= 1'b1;
					else if (i_wr)
						bit_q <= 1'b0;
				mgmt_attr_pkg::ATTR_RC:
					if (i_cond)
						bit_q <= 1'b1;
					else if (i_rd)
						bit_q <= 1'b0;
				mgmt_attr_pkg::ATTR_LL:
					if (!i_cond)
						bit_q <= 1'b0;
					else if (i_rd)
						bit_q <= 1'b1;
				mgmt_attr_pkg::ATTR_LH:
					if (i_cond)
						bit_q <= 1'b1;
					else if (i_rd)
						bit_q <= 1'b0;
				mgmt_attr_pkg::ATTR_SC:
					if (i_wr && i_wdata)
						bit_q <= 1'b1;
					else if (bit_q && i_cond)
						bit_q <= 1'b0;
				mgmt_attr_pkg::ATTR_SS:
					if (i_wr && !i_wdata)
						bit_q <= 1'b0;
					else if (!bit_q && i_cond)
						bit_q <= 1'b1;
				default:
					bit_q <= bit_q;
			endcase
		end
	end

	// write-only bits read as zero; reserved read as zero
	assign o_val = (ATTR == 4'(mgmt_attr_pkg::ATTR_WO) || ATTR == 4'(mgmt_attr_pkg::ATTR_RSVD))
		? 1'b0 : bit_q;
endmodule // mgmt_attr_bit
`default_nettype wire

// ### core/mgmt_mmd_port.sv
// indirect access to extended device registers through index 13 and 14
// assumes a one-cycle write strobe per management frame
`timescale 1ns/10ps
`default_nettype none
module mgmt_mmd_port (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_soft_rst,
	input wire logic i_wr_ctrl,
	input wire logic i_wr_data,
	input wire logic i_rd_data,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] i_mmd_rdata,
	output logic [15:0] o_ctrl,
	output logic [15:0] o_data,
	output logic [4:0] o_mmd_dev,
	output logic [15:0] o_mmd_addr,
	output logic [15:0] o_mmd_wdata,
	output logic o_mmd_wr,
	output logic o_mmd_rd
);
	logic [15:0] ctrl_q;
	logic [15:0] addr_q;
	logic [15:0] wdata_q;
	logic wr_q;
	logic rd_q;
	logic addr_mode;

	assign addr_mode = ctrl_q[mgmt_attr_pkg::MMD_FUNC_MSB:mgmt_attr_pkg::MMD_FUNC_LSB]
		== mgmt_attr_pkg::MMD_FUNC_ADDR;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b || i_soft_rst)
			ctrl_q <= mgmt_attr_pkg::MMD_CTRL_RESET;
		else if (i_wr_ctrl)
			ctrl_q <= i_wdata;
	end

	// address phase stores the target, data phase goes out to the device
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b || i_soft_rst)
			addr_q <= mgmt_attr_pkg::MMD_DATA_RESET;
		else if (i_wr_data && addr_mode)
			addr_q <= i_wdata;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			wdata_q <= mgmt_attr_pkg::MMD_DATA_RESET;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end
		else
		begin
			wr_q <= i_wr_data && !addr_mode;
			rd_q <= i_rd_data && !addr_mode;
			if (i_wr_data && !addr_mode)
				wdata_q <= i_wdata;
		end
	end

	assign o_ctrl = ctrl_q;
	assign o_data = addr_mode ? addr_q : i_mmd_rdata;
	assign o_mmd_dev = ctrl_q[mgmt_attr_pkg::MMD_DEV_MSB:mgmt_attr_pkg::MMD_DEV_LSB];
	assign o_mmd_addr = addr_q;
	assign o_mmd_wdata = wdata_q;
	assign o_mmd_wr = wr_q;
	assign o_mmd_rd = rd_q;
endmodule // mgmt_mmd_port
`default_nettype wire

// ### core/mgmt_register_attribute_logic.sv
// management register bank: attribute-driven bits behind a decoded index
// assumes a frame decoder gives one-cycle read and write strobes with index
`timescale 1ns/10ps
`default_nettype none
module mgmt_register_attribute_logic #(
	parameter int NREG = 2,
	// per register: index and per-bit attributes, immunity and reset values
	parameter logic [NREG*5-1:0] REG_INDEX = {5'h01, 5'h00},
	parameter logic [NREG*16*4-1:0] REG_ATTR = {
		{4'h8, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
			4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0},
		{4'h9, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h9, 4'h1,
			4'h1, 4'ha, 4'hb, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0}},
	parameter logic [NREG*16-1:0] REG_IMMUNE = {16'h0000, 16'h0000},
	parameter logic [NREG*16-1:0] REG_RESET = {16'h0000, 16'h0000}
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [4:0] i_index,
	input wire logic [15:0] i_wdata,
	input wire logic [NREG*16-1:0] i_cond,
	input wire logic [15:0] i_mmd_rdata,
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	output logic o_soft_rst,
	output logic [NREG*16-1:0] o_reg_bits,
	output logic [4:0] o_mmd_dev,
	output logic [15:0] o_mmd_addr,
	output logic [15:0] o_mmd_wdata,
	output logic o_mmd_wr,
	output logic o_mmd_rd
);
	logic [NREG-1:0] hit;
	logic [NREG*16-1:0] bits;
	logic soft_rst_q;
	logic [15:0] rdata_q;
	logic rvalid_q;
	logic [15:0] mmd_ctrl;
	logic [15:0] mmd_data;
	logic sel_ctrl;
	logic sel_data;
	logic [15:0] mux;

	assign sel_ctrl = i_index == mgmt_attr_pkg::IDX_MMD_CTRL;
	assign sel_data = i_index == mgmt_attr_pkg::IDX_MMD_DATA;

	genvar r, b;
	generate
		for (r = 0; r < NREG; r++)
		begin : g_reg
			assign hit[r] = i_index == REG_INDEX[r*5 +: 5];
			for (b = 0; b < 16; b++)
			begin : g_bit
				mgmt_attr_bit #(
					.ATTR(REG_ATTR[(r*16+b)*4 +: 4]),
					.RESET_VAL(REG_RESET[r*16+b]),
					.IMMUNE(REG_IMMUNE[r*16+b])
				) u_bit (
					.i_sys_clk(i_sys_clk),
					.i_rst_b(i_rst_b),
					.i_soft_rst(soft_rst_q),
					.i_wr(i_wr && hit[r]),
					.i_wdata(i_wdata[b]),
					.i_rd(i_rd && hit[r]),
					.i_cond(i_cond[r*16+b]),
					.o_val(bits[r*16+b])
				);
			end
		end
	endgenerate

	// software reset: bit 15 of the register at index 0, one cycle pulse
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= i_wr && i_index == mgmt_attr_pkg::IDX_BASIC_CTRL
				&& i_wdata[mgmt_attr_pkg::SOFT_RST_BIT];
	end

	mgmt_mmd_port u_mmd (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_soft_rst(soft_rst_q),
		.i_wr_ctrl(i_wr && sel_ctrl),
		.i_wr_data(i_wr && sel_data),
		.i_rd_data(i_rd && sel_data),
		.i_wdata(i_wdata),
		.i_mmd_rdata(i_mmd_rdata),
		.o_ctrl(mmd_ctrl),
		.o_data(mmd_data),
		.o_mmd_dev(o_mmd_dev),
		.o_mmd_addr(o_mmd_addr),
		.o_mmd_wdata(o_mmd_wdata),
		.o_mmd_wr(o_mmd_wr),
		.o_mmd_rd(o_mmd_rd)
	);

	// read data sampled before the clear side effects land
	always_comb
	begin
		mux = 16'h0000;
		if (sel_ctrl)
			mux = mmd_ctrl;
		else if (sel_data)
			mux = mmd_data;
		for (int k = 0; k < NREG; k++)
			if (hit[k])
				mux = bits[k*16 +: 16];
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			rdata_q <= mgmt_attr_pkg::RESET_WORD;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= i_rd;
			if (i_rd)
				rdata_q <= mux;
		end
	end

	assign o_rdata = rdata_q;
	assign o_rvalid = rvalid_q;
	assign o_soft_rst = soft_rst_q;
	assign o_reg_bits = bits;
endmodule // mgmt_register_attribute_logic
`default_nettype wire

// ### verification/mgmt_attr_properties.sv
// assertions on the attribute bank ports
// assumes the default index 0 and index 1 bit map
`timescale 1ns/10ps
`default_nettype none
module mgmt_attr_checker #(parameter int NREG = 2) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [4:0] i_index,
	input wire logic [15:0] i_wdata,
	input wire logic [NREG*16-1:0] i_cond,
	input wire logic [15:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_soft_rst,
	input wire logic [NREG*16-1:0] o_reg_bits
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_wr0;
		i_wr && i_index == 5'h00;
	endsequence
	sequence s_wr1;
		i_wr && i_index == 5'h01;
	endsequence
	property p_rv; i_rd |=> o_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read unanswered");
	property p_soft; s_wr0 ##0 i_wdata[15] |=> o_soft_rst; endproperty
	a_soft: assert property (p_soft) else $error("no soft reset");
	property p_rw; s_wr0 ##0 !i_wdata[15] && !o_soft_rst
		|=> o_reg_bits[13:10] == $past(i_wdata[13:10]); endproperty
	a_rw: assert property (p_rw) else $error("rw not stored");
	property p_wc; s_wr1 ##0 i_wdata[11] && !i_cond[27] |=> !o_reg_bits[27]; endproperty
	a_wc: assert property (p_wc) else $error("wc kept");
	property p_wac; s_wr1 ##0 !i_cond[26] |=> !o_reg_bits[26]; endproperty
	a_wac: assert property (p_wac) else $error("wac kept");
	property p_rc; i_rd && i_index == 5'h01 && o_reg_bits[25] && !i_cond[25]
		|=> o_rdata[9] && !o_reg_bits[25]; endproperty
	a_rc: assert property (p_rc) else $error("rc wrong");
	property p_lh; o_reg_bits[23] && !i_rd && !i_wr && !o_soft_rst |=> o_reg_bits[23]; endproperty
	a_lh: assert property (p_lh) else $error("lh dropped");
	property p_sc; o_reg_bits[9] && i_cond[9] && !i_wr |=> !o_reg_bits[9]; endproperty
	a_sc: assert property (p_sc) else $error("sc stuck");
	property p_ll; !o_reg_bits[24] && !(i_rd && i_index == 5'h01) |=> !o_reg_bits[24];
	endproperty
	a_ll: assert property (p_ll) else $error("ll released");
endmodule // mgmt_attr_checker
bind mgmt_register_attribute_logic mgmt_attr_checker #(.NREG(NREG)) chk (.i_sys_clk,
	.i_rst_b, .i_wr, .i_rd, .i_index, .i_wdata, .i_cond, .o_rdata, .o_rvalid, .o_soft_rst,
	.o_reg_bits);
`default_nettype wire

// ### verification/mgmt_station.sv
// station model: one-word register frames
// assumes strobes are taken at the rising edge
`timescale 1ns/10ps
`default_nettype none
module mgmt_station (
	input wire logic i_sys_clk,
	input wire logic i_rvalid,
	input wire logic [15:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [4:0] o_index,
	output logic [15:0] o_wdata
);
	initial {o_wr, o_rd, o_index, o_wdata} = '0;
	// callers keep reserved fields zero
	// released lines flip so stale values never pass
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		@(posedge i_sys_clk);
		{o_wr, o_index, o_wdata} <= {1'b1, i, d};
		@(posedge i_sys_clk);
		{o_wr, o_index, o_wdata} <= {1'b0, ~i, ~d};
		@(negedge i_sys_clk);
	endtask
	task automatic rd(input logic [4:0] i, output logic [15:0] q);
		@(posedge i_sys_clk);
		{o_rd, o_index} <= {1'b1, i};
		@(posedge i_sys_clk);
		{o_rd, o_index} <= {1'b0, ~i};
		@(negedge i_sys_clk);
		q = i_rvalid ? i_rdata : 16'hxxxx;
	endtask
endmodule // mgmt_station
`default_nettype wire

// ### verification/tb.sv
// bench for the attribute bank driven by the station model
// assumes the default map with bit 14 of index 0 made immune
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [31:0] cond = 32'h0000_8000;
	logic [31:0] bits;
	logic [15:0] q, rdata, wd, maddr, mwd;
	logic [4:0] idx, mdev;
	logic wr, rd, rv, srst, mwr, mrd;
	int err_total = 0;
	int samples_checked = 0;
	always #20 i_sys_clk = ~i_sys_clk;
	mgmt_station sta (.i_sys_clk, .i_rvalid(rv), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
		.o_index(idx), .o_wdata(wd));
	mgmt_register_attribute_logic #(.REG_IMMUNE({16'h0000, 16'h4000})) DUT (.i_sys_clk,
		.i_rst_b, .i_wr(wr), .i_rd(rd), .i_index(idx), .i_wdata(wd), .i_cond(cond),
		.i_mmd_rdata(16'h5a5a), .o_rdata(rdata), .o_rvalid(rv), .o_soft_rst(srst),
		.o_reg_bits(bits), .o_mmd_dev(mdev), .o_mmd_addr(maddr), .o_mmd_wdata(mwd),
		.o_mmd_wr(mwr), .o_mmd_rd(mrd));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask
	task automatic pulse(input int b);
		@(posedge i_sys_clk) cond[b] <= 1'b1;
		@(posedge i_sys_clk) cond[b] <= 1'b0;
		cyc(2);
	endtask
	task automatic t_ctrl;
		sta.wr(5'h00, 16'h5580);
		sta.rd(5'h00, q);
		`CHK(q & 16'h7d80, 16'h5580)
		// soft reset with rw bits set: the immune one must survive, the rest must not
		sta.wr(5'h00, 16'hd580);
		`CHK(srst, 1'b1)
		cyc(2);
		`CHK(bits[15:0] & 16'hfd80, 16'h4000)
	endtask
	task automatic t_self;
		sta.wr(5'h00, 16'h0240);
		`CHK(bits[9:6], 4'h8)
		@(posedge i_sys_clk) cond[9:5] <= 5'h13;
		cyc(2);
		`CHK({bits[9], bits[6:5]}, 3'h3)
		@(posedge i_sys_clk) cond[9:5] <= 5'h00;
		sta.wr(5'h00, 16'h0000);
		`CHK(bits[5], 1'b0)
	endtask
	task automatic t_stat;
		sta.wr(5'h01, 16'hff80);
		`CHK(bits[31:16] & 16'h6280, 16'h0000)
		pulse(27);
		pulse(26);
		sta.wr(5'h01, 16'h0000);
		`CHK(bits[27:26], 2'h2)
		sta.wr(5'h01, 16'h0800);
		`CHK(bits[27], 1'b0)
	endtask
	task automatic t_latch;
		@(posedge i_sys_clk) cond[24] <= 1'b1;
		pulse(25);
		pulse(23);
		cyc(3);
		sta.rd(5'h01, q);
		`CHK(q[9:7], 3'h5)
		sta.rd(5'h01, q);
		`CHK(q[9:7], 3'h2)
		@(posedge i_sys_clk) cond[24:23] <= 2'h1;
		@(posedge i_sys_clk) cond[24] <= 1'b1;
		cyc(2);
		sta.rd(5'h01, q);
		`CHK(q[8:7], 2'h1)
		sta.rd(5'h01, q);
		`CHK(q[8:7], 2'h3)
	endtask
	task automatic t_ext;
		sta.wr(5'h0d, 16'h0003);
		sta.wr(5'h0e, 16'h0020);
		`CHK(maddr, 16'h0020)
		sta.wr(5'h0d, 16'h4003);
		sta.wr(5'h0e, 16'habcd);
		`CHK(mwr, 1'b1)
		`CHK(mwd, 16'habcd)
		`CHK(mdev, 5'h03)
		`CHK(maddr, 16'h0020)
		sta.rd(5'h0e, q);
		`CHK(q, 16'h5a5a)
		`CHK(mrd, 1'b1)
		sta.rd(5'h0d, q);
		`CHK(q, 16'h4003)
		sta.rd(5'h05, q);
		`CHK(q, 16'h0000)
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		t_ctrl();
		t_self();
		t_stat();
		t_latch();
		t_ext();
		print_verdict();
	end
	// the tests need under a hundred cycles
	initial
	begin
		repeat (3000) @(posedge i_sys_clk);
		err_total++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire
